// ---- core/cond_addr_pkg.sv ----
// constants, field layouts and types for the condition and addressing block
package cond_addr_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] ADDR_CMD = 8'h00;
   localparam logic [7:0] ADDR_PSR = 8'h04;
   localparam logic [7:0] ADDR_BASE = 8'h08;
   localparam logic [7:0] ADDR_OFFSET = 8'h0c;
   localparam logic [7:0] ADDR_SHIFT = 8'h10;
   localparam logic [7:0] ADDR_IMM = 8'h14;
   localparam logic [7:0] ADDR_SRC = 8'h18;
   localparam logic [7:0] ADDR_RESULT = 8'h1c;
   localparam logic [7:0] ADDR_XFER = 8'h20;
   localparam logic [7:0] ADDR_STATUS = 8'h24;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // command word fields
   localparam int CMD_COND_LSB = 0;
   localparam int CMD_OP_LSB = 4;
   localparam int CMD_UP_BIT = 7;
   localparam int CMD_IDX_LSB = 8;
   localparam int CMD_SHK_LSB = 10;
   localparam int CMD_SHREG_BIT = 13;
   localparam int CMD_IMM_BIT = 14;
   localparam int CMD_MASK_LSB = 15;
   localparam int CMD_MULTI_LSB = 19;
   localparam int CMD_SHAMT_LSB = 21;
   // status register: flag positions and field mask bits
   localparam int PSR_N = 31;
   localparam int PSR_Z = 30;
   localparam int PSR_C = 29;
   localparam int PSR_V = 28;
   localparam int MASK_FLAGS = 0;
   localparam int MASK_STATUS = 1;
   localparam int MASK_EXT = 2;
   localparam int MASK_CTRL = 3;
   // status word bits
   localparam int ST_PASS = 0;
   localparam int ST_CARRY = 1;
   localparam int ST_WB = 2;
   localparam int ST_DONE = 3;
   localparam int COPROC_SCALE = 2;
   typedef enum logic [3:0] {
      cond_equal, cond_not_equal, cond_unsigned_higher_same, cond_unsigned_lower,
      cond_minus, cond_plus, cond_overflow, cond_no_overflow,
      cond_unsigned_higher, cond_unsigned_lower_same, cond_greater_equal, cond_less,
      cond_greater, cond_less_equal, cond_always, cond_reserved
   } cond_t;
   typedef enum logic [2:0] {
      shift_left_logical, shift_right_logical, shift_right_arith,
      rotate_right, rotate_right_through_carry
   } shift_t;
   typedef enum logic [2:0] {
      OP_OPERAND, OP_PSR, OP_WORD_BYTE, OP_HALF_SIGNED, OP_MULTI, OP_COPROC
   } op_t;
   typedef enum logic [1:0] {IDX_OFFSET, IDX_PRE, IDX_POST} index_t;
   typedef enum logic [1:0] {inc_after, inc_before, dec_after, dec_before} multi_t;
   // stack aliases, same for loads and stores
   localparam multi_t stack_full_desc = inc_after;
   localparam multi_t stack_empty_desc = inc_before;
   localparam multi_t stack_full_asc = dec_after;
   localparam multi_t stack_empty_asc = dec_before;
endpackage

// ---- core/cond_check.sv ----
// condition code test against the four flags
`timescale 1ns/10ps
`default_nettype none
module cond_check (
   input wire logic [3:0] cond,
   input wire logic [3:0] flags,
   output logic pass
);
   logic n;
   logic z;
   logic c;
   logic v;
   assign n = flags[3];
   assign z = flags[2];
   assign c = flags[1];
   assign v = flags[0];
   always_comb begin
      case (cond_addr_pkg::cond_t'(cond))
         cond_addr_pkg::cond_equal: pass = z;
         cond_addr_pkg::cond_not_equal: pass = !z;
         cond_addr_pkg::cond_unsigned_higher_same: pass = c;
         cond_addr_pkg::cond_unsigned_lower: pass = !c;
         cond_addr_pkg::cond_minus: pass = n;
         cond_addr_pkg::cond_plus: pass = !n;
         cond_addr_pkg::cond_overflow: pass = v;
         cond_addr_pkg::cond_no_overflow: pass = !v;
         cond_addr_pkg::cond_unsigned_higher: pass = c && !z;
         // taken as printed: both carry clear and zero set
         cond_addr_pkg::cond_unsigned_lower_same: pass = !c && z;
         cond_addr_pkg::cond_greater_equal: pass = (n == v);
         cond_addr_pkg::cond_less: pass = (n != v);
         cond_addr_pkg::cond_greater: pass = !z && (n == v);
         cond_addr_pkg::cond_less_equal: pass = z || (n != v);
         cond_addr_pkg::cond_always: pass = 1'b1;
         default: pass = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// ---- core/cond_eval_and_addr_modes.sv ----
// condition evaluation, second operand, status masks and address modes on AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
// How it works
// - equal/not-equal on zero, minus/plus on negative, overflow pair on overflow flag
// - higher-or-same passes on carry set, lower on carry clear
// - higher needs carry set, zero clear; lower-or-same needs carry clear, zero set
// - greater-or-equal when negative equals overflow, less when they differ
// - greater needs zero clear and negative equal to overflow
// - less-or-equal on zero set or flags differing; always ignores flags
// - mask bit 3 writes control field, bit 2 writes extension field
// - mask bit 0 writes flags, bit 1 status; unmasked fields keep value
// - second operand is immediate or register shifted by a 5-bit immediate
// - shift amount may come from a register; rotate through carry by one
// - word/byte address is base plus or minus 12-bit immediate or register
// - word/byte offset register may be scaled by any shift or carry rotate
// - pre-indexed uses base plus offset and writes it back to base
// - post-indexed uses plain base, then writes base plus/minus offset back
// - halfword/signed-byte use 8-bit immediate or plain register, three forms
// - multiple transfers: four increment/decrement modes mapped onto stack types
// - coprocessor offset is 8-bit immediate times four, three forms
module cond_eval_and_addr_modes (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic awvalid,
   output logic awready,
   input wire logic [cond_addr_pkg::ADDR_W-1:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [cond_addr_pkg::ADDR_W-1:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   typedef enum logic {ST_IDLE, ST_EXEC} state_t;

   function automatic logic [31:0] applyStrb(input logic [31:0] old, input logic [31:0] data,
                                             input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic isMapped(input logic [cond_addr_pkg::ADDR_W-1:0] a);
      return (a[1:0] == 2'h0) && (a <= cond_addr_pkg::ADDR_STATUS);
   endfunction

   function automatic logic [31:0] addSub(input logic up, input logic [31:0] a, input logic [31:0] b);
      return up ? a + b : a - b;
   endfunction

   state_t state_r;
   logic [cond_addr_pkg::ADDR_W-1:0] wAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic wrFire;
   logic [31:0] cmd_r;
   logic [31:0] psr_r;
   logic [31:0] base_r;
   logic [31:0] offsetReg_r;
   logic [31:0] shiftReg_r;
   logic [31:0] imm_r;
   logic [31:0] src_r;
   logic [31:0] result_r;
   logic [31:0] xfer_r;
   logic [3:0] status_r;
   logic [31:0] readData;
   logic condPass;
   logic execute;

   // decoded command fields
   cond_addr_pkg::op_t op;
   cond_addr_pkg::index_t idx;
   cond_addr_pkg::multi_t multiMode;
   logic up;
   logic useImm;
   logic [3:0] fieldMask;

   // computed results of the instruction
   logic [31:0] opResult;
   logic [31:0] opAddr;
   logic [31:0] newBase;
   logic [31:0] newPsr;
   logic [31:0] offset;
   logic [31:0] span;
   logic [31:0] srcVal;
   logic doWb;
   logic doPsr;
   logic doResult;
   logic carryOut;

   shift_if sh ();

   operand_shifter uShift (
      .sh(sh)
   );

   cond_check uCond (
      .cond(cmd_r[cond_addr_pkg::CMD_COND_LSB +: 4]),
      .flags(psr_r[cond_addr_pkg::PSR_V +: 4]),
      .pass(condPass)
   );

   assign op = cond_addr_pkg::op_t'(cmd_r[cond_addr_pkg::CMD_OP_LSB +: 3]);
   assign idx = cond_addr_pkg::index_t'(cmd_r[cond_addr_pkg::CMD_IDX_LSB +: 2]);
   assign multiMode = cond_addr_pkg::multi_t'(cmd_r[cond_addr_pkg::CMD_MULTI_LSB +: 2]);
   assign up = cmd_r[cond_addr_pkg::CMD_UP_BIT];
   assign useImm = cmd_r[cond_addr_pkg::CMD_IMM_BIT];
   assign fieldMask = cmd_r[cond_addr_pkg::CMD_MASK_LSB +: 4];

   // one shifter serves both the second operand and the scaled offset
   assign sh.value = offsetReg_r;
   assign sh.kind = cond_addr_pkg::shift_t'(cmd_r[cond_addr_pkg::CMD_SHK_LSB +: 3]);
   assign sh.amount = cmd_r[cond_addr_pkg::CMD_SHREG_BIT] ? shiftReg_r[7:0]
                      : {3'h0, cmd_r[cond_addr_pkg::CMD_SHAMT_LSB +: 5]};
   assign sh.carryIn = psr_r[cond_addr_pkg::PSR_C];

   // write channel: address and data are taken in either order
   assign wrFire = !awready && !wready && !bvalid;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         awready <= 1'b1;
         wready <= 1'b1;
         bvalid <= 1'b0;
         bresp <= cond_addr_pkg::RESP_OKAY;
         wAddr_r <= '0;
         wData_r <= cond_addr_pkg::RST_WORD;
         wStrb_r <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            wAddr_r <= awaddr;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            wData_r <= wdata;
            wStrb_r <= wstrb;
            wready <= 1'b0;
         end
         if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= isMapped(wAddr_r) ? cond_addr_pkg::RESP_OKAY : cond_addr_pkg::RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // read channel: one outstanding read, data registered with the answer
   always_comb begin
      case (araddr)
         cond_addr_pkg::ADDR_CMD: readData = cmd_r;
         cond_addr_pkg::ADDR_PSR: readData = psr_r;
         cond_addr_pkg::ADDR_BASE: readData = base_r;
         cond_addr_pkg::ADDR_OFFSET: readData = offsetReg_r;
         cond_addr_pkg::ADDR_SHIFT: readData = shiftReg_r;
         cond_addr_pkg::ADDR_IMM: readData = imm_r;
         cond_addr_pkg::ADDR_SRC: readData = src_r;
         cond_addr_pkg::ADDR_RESULT: readData = result_r;
         cond_addr_pkg::ADDR_XFER: readData = xfer_r;
         cond_addr_pkg::ADDR_STATUS: readData = {28'h0, status_r};
         default: readData = 32'h0;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= cond_addr_pkg::RST_WORD;
         rresp <= cond_addr_pkg::RESP_OKAY;
      end else begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= readData;
            rresp <= isMapped(araddr) ? cond_addr_pkg::RESP_OKAY : cond_addr_pkg::RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // a command write runs the instruction in the following cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else if (wrFire && wAddr_r == cond_addr_pkg::ADDR_CMD) begin
         state_r <= ST_EXEC;
      end else begin
         state_r <= ST_IDLE;
      end
   end

   assign execute = (state_r == ST_EXEC);

   // instruction datapath
   always_comb begin
      opResult = result_r;
      opAddr = xfer_r;
      newBase = base_r;
      newPsr = psr_r;
      offset = 32'h0;
      span = 32'h0;
      srcVal = useImm ? imm_r : src_r;
      doWb = 1'b0;
      doPsr = 1'b0;
      doResult = 1'b0;
      carryOut = psr_r[cond_addr_pkg::PSR_C];
      case (op)
         cond_addr_pkg::OP_OPERAND: begin
            doResult = 1'b1;
            if (useImm) begin
               opResult = imm_r;
            end else begin
               opResult = sh.result;
               carryOut = sh.carryOut;
            end
         end
         cond_addr_pkg::OP_PSR: begin
            doPsr = 1'b1;
            for (int f = 0; f < 4; f++) begin
               // flags live in the top byte, control in the bottom one
               if (fieldMask[f]) begin
                  newPsr[(3-f)*8 +: 8] = srcVal[(3-f)*8 +: 8];
               end
            end
            opResult = newPsr;
         end
         cond_addr_pkg::OP_WORD_BYTE, cond_addr_pkg::OP_HALF_SIGNED, cond_addr_pkg::OP_COPROC: begin
            if (op == cond_addr_pkg::OP_WORD_BYTE) begin
               offset = useImm ? {20'h0, imm_r[11:0]} : sh.result;
            end else if (op == cond_addr_pkg::OP_HALF_SIGNED) begin
               offset = useImm ? {24'h0, imm_r[7:0]} : offsetReg_r;
            end else begin
               offset = {24'h0, imm_r[7:0]} << cond_addr_pkg::COPROC_SCALE;
            end
            newBase = addSub(up, base_r, offset);
            doResult = 1'b1;
            opResult = offset;
            // post-indexed transfers at the old base; both indexed forms update it
            opAddr = (idx == cond_addr_pkg::IDX_POST) ? base_r : newBase;
            doWb = (idx == cond_addr_pkg::IDX_PRE) || (idx == cond_addr_pkg::IDX_POST);
         end
         cond_addr_pkg::OP_MULTI: begin
            // register count in the low immediate bits; four bytes per register
            span = {25'h0, imm_r[4:0], 2'h0};
            doResult = 1'b1;
            opResult = span;
            doWb = (idx != cond_addr_pkg::IDX_OFFSET);
            case (multiMode)
               cond_addr_pkg::stack_full_desc: begin
                  opAddr = base_r;
                  newBase = base_r + span;
               end
               cond_addr_pkg::stack_empty_desc: begin
                  opAddr = base_r + 32'h4;
                  newBase = base_r + span;
               end
               cond_addr_pkg::stack_full_asc: begin
                  opAddr = base_r - span + 32'h4;
                  newBase = base_r - span;
               end
               cond_addr_pkg::stack_empty_asc: begin
                  opAddr = base_r - span;
                  newBase = base_r - span;
               end
               default: begin
                  opAddr = base_r;
                  newBase = base_r;
               end
            endcase
         end
         default: begin
            doResult = 1'b0;
         end
      endcase
   end

   // software-written registers
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cmd_r <= cond_addr_pkg::RST_WORD;
         offsetReg_r <= cond_addr_pkg::RST_WORD;
         shiftReg_r <= cond_addr_pkg::RST_WORD;
         imm_r <= cond_addr_pkg::RST_WORD;
         src_r <= cond_addr_pkg::RST_WORD;
      end else if (wrFire) begin
         case (wAddr_r)
            cond_addr_pkg::ADDR_CMD: cmd_r <= applyStrb(cmd_r, wData_r, wStrb_r);
            cond_addr_pkg::ADDR_OFFSET: offsetReg_r <= applyStrb(offsetReg_r, wData_r, wStrb_r);
            cond_addr_pkg::ADDR_SHIFT: shiftReg_r <= applyStrb(shiftReg_r, wData_r, wStrb_r);
            cond_addr_pkg::ADDR_IMM: imm_r <= applyStrb(imm_r, wData_r, wStrb_r);
            cond_addr_pkg::ADDR_SRC: src_r <= applyStrb(src_r, wData_r, wStrb_r);
            default: ;
         endcase
      end
   end

   // status register: bus write, a passing field write, or the carry out of a passing operand
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         psr_r <= cond_addr_pkg::RST_WORD;
      end else if (wrFire && wAddr_r == cond_addr_pkg::ADDR_PSR) begin
         psr_r <= applyStrb(psr_r, wData_r, wStrb_r);
      end else if (execute && condPass && doPsr) begin
         psr_r <= newPsr;
      end else if (execute && condPass && op == cond_addr_pkg::OP_OPERAND) begin
         psr_r[cond_addr_pkg::PSR_C] <= carryOut;
      end
   end

   // base register: bus write or write-back of a passing indexed transfer
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         base_r <= cond_addr_pkg::RST_WORD;
      end else if (wrFire && wAddr_r == cond_addr_pkg::ADDR_BASE) begin
         base_r <= applyStrb(base_r, wData_r, wStrb_r);
      end else if (execute && condPass && doWb) begin
         base_r <= newBase;
      end
   end

   // results; a failing condition leaves them as they were
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         result_r <= cond_addr_pkg::RST_WORD;
         xfer_r <= cond_addr_pkg::RST_WORD;
      end else if (execute && condPass && doResult) begin
         result_r <= opResult;
         xfer_r <= opAddr;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         status_r <= 4'h0;
      end else if (wrFire && wAddr_r == cond_addr_pkg::ADDR_CMD) begin
         status_r <= 4'h0;
      end else if (execute) begin
         status_r[cond_addr_pkg::ST_PASS] <= condPass;
         status_r[cond_addr_pkg::ST_CARRY] <= carryOut;
         status_r[cond_addr_pkg::ST_WB] <= condPass && doWb;
         status_r[cond_addr_pkg::ST_DONE] <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- core/operand_shifter.sv ----
// barrel shifter with carry out for operands and scaled offsets
`timescale 1ns/10ps
`default_nettype none
module operand_shifter (
   shift_if.shifter sh
);
   logic [32:0] wide;
   logic [4:0] rot;
   always_comb begin
      wide = 33'h0;
      rot = sh.amount[4:0];
      sh.result = sh.value;
      sh.carryOut = sh.carryIn;
      case (sh.kind)
         cond_addr_pkg::shift_left_logical: begin
            wide = {1'b0, sh.value} << sh.amount;
            if (sh.amount != 8'h0 && sh.amount <= 8'h20) begin
               sh.result = wide[31:0];
               sh.carryOut = wide[32];
            end else if (sh.amount > 8'h20) begin
               sh.result = 32'h0;
               sh.carryOut = 1'b0;
            end
         end
         cond_addr_pkg::shift_right_logical: begin
            if (sh.amount != 8'h0 && sh.amount < 8'h20) begin
               sh.result = sh.value >> sh.amount;
               sh.carryOut = sh.value[rot - 5'h1];
            end else if (sh.amount != 8'h0) begin
               sh.result = 32'h0;
               sh.carryOut = (sh.amount == 8'h20) ? sh.value[31] : 1'b0;
            end
         end
         cond_addr_pkg::shift_right_arith: begin
            if (sh.amount != 8'h0 && sh.amount < 8'h20) begin
               sh.result = $unsigned($signed(sh.value) >>> sh.amount);
               sh.carryOut = sh.value[rot - 5'h1];
            end else if (sh.amount != 8'h0) begin
               sh.result = {32{sh.value[31]}};
               sh.carryOut = sh.value[31];
            end
         end
         cond_addr_pkg::rotate_right: begin
            // amounts past 31 wrap; a multiple of 32 leaves the value but carries bit 31
            if (sh.amount != 8'h0 && rot == 5'h0) begin
               sh.carryOut = sh.value[31];
            end else if (sh.amount != 8'h0) begin
               sh.result = (sh.value >> rot) | (sh.value << (6'h20 - {1'b0, rot}));
               sh.carryOut = sh.value[rot - 5'h1];
            end
         end
         cond_addr_pkg::rotate_right_through_carry: begin
            sh.result = {sh.carryIn, sh.value[31:1]};
            sh.carryOut = sh.value[0];
         end
         default: begin
            sh.result = sh.value;
            sh.carryOut = sh.carryIn;
         end
      endcase
   end
endmodule
`default_nettype wire

// ---- core/shift_if.sv ----
// bundle between the block and its barrel shifter
`timescale 1ns/10ps
`default_nettype none
interface shift_if;
   logic [31:0] value;
   cond_addr_pkg::shift_t kind;
   logic [7:0] amount;
   logic carryIn;
   logic [31:0] result;
   logic carryOut;
   modport shifter(input value, input kind, input amount, input carryIn, output result, output carryOut);
   modport user(output value, output kind, output amount, output carryIn, input result, input carryOut);
endinterface
`default_nettype wire

// ---- dv/cond_addr_sva.sv ----
// register bus handshake assertions and a status write-back check for the condition and address block
`timescale 1ns/10ps
`default_nettype none
module cond_addr_sva (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [7:0] araddr,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   sequence s_wtake; awvalid && awready && wvalid && wready; endsequence
   sequence s_bdone; bvalid && bready; endsequence
   property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped early");
   property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer changed early");
   property p_wans; s_wtake |-> ##[1:2] bvalid; endproperty
   a_wans: assert property (p_wans) else $error("write answer late");
   property p_rans; arvalid && arready |=> rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_bend; s_bdone |=> !bvalid && awready && wready; endproperty
   a_bend: assert property (p_bend) else $error("write channel not reopened");
   property p_rend; rvalid && rready |=> !rvalid && arready; endproperty
   a_rend: assert property (p_rend) else $error("read channel not reopened");
   property p_wblk; bvalid |-> !awready && !wready; endproperty
   a_wblk: assert property (p_wblk) else $error("second write taken");
   property p_rblk; rvalid |-> !arready; endproperty
   a_rblk: assert property (p_rblk) else $error("second read taken");
   // a base write-back can only be reported together with a passing condition
   property p_wbpass; arvalid && arready && araddr == cond_addr_pkg::ADDR_STATUS |=> !rdata[2] || rdata[0]; endproperty
   a_wbpass: assert property (p_wbpass) else $error("write-back without pass");
endmodule
bind cond_eval_and_addr_modes cond_addr_sva i_cond_addr_sva (.clock(clock), .rst_n(rst_n), .awvalid(awvalid),
   .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
   .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
   .rresp(rresp));
`default_nettype wire

// ---- dv/tb_top.sv ----
// self-checking bench driving the block over its register bus
`timescale 1ns/10ps
`default_nettype none
`define chk(nm, e, s) begin checks_done++; if ((e) !== (s)) begin errors++; \
   $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module tb_top;
   logic clock = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, v, u, e, nb, x, b, o, im;
   logic [3:0] wstrb = 4'hf, c, f;
   logic [1:0] bresp, rresp, rs;
   int errors = 0, checks_done = 0, cyc = 0, seed = 32'h7eaa, k, op;
   cond_eval_and_addr_modes i_cond_eval_and_addr_modes (.clock(clock), .rst_n(rst_n), .awvalid(awvalid),
      .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   initial forever #12.5 clock = ~clock;
   task final_report;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // whole run needs about 7600 cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         final_report;
      end
   end
   task automatic wr(logic [7:0] a, logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clock);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
         if (bready && bvalid) begin
            bready <= 0;
            rs = bresp;
         end
      end while (awvalid || wvalid || bready);
      // one idle edge so a following call never re-raises bready in the same step
      @(posedge clock);
   endtask
   task automatic rd(logic [7:0] a);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge clock);
         if (arvalid && arready) arvalid <= 0;
         if (rready && rvalid) begin
            rready <= 0;
            v = rdata;
            rs = rresp;
         end
      end while (arvalid || rready);
      @(posedge clock);
   endtask
   function automatic logic [31:0] shf(logic [31:0] d, int kd, int s, logic cy);
      case (kd)
         0: return d << s;
         1: return d >> s;
         2: return $signed(d) >>> s;
         3: return (d >> s) | (d << (32 - s));
         default: return {cy, d[31:1]};
      endcase
   endfunction
   function automatic logic cp(logic [3:0] cc, logic [3:0] fl);
      logic n, z, y, w;
      logic [15:0] t;
      {n, z, y, w} = fl;
      t = {1'b0, 1'b1, z | (n ^ w), !z & !(n ^ w), n ^ w, !(n ^ w), !y & z, y & !z, !w, w, !n, n, !y, y, !z, z};
      return t[cc];
   endfunction
   initial begin
      repeat (20) @(posedge clock);
      rst_n <= 1;
      @(posedge clock);
      for (k = 0; k < 256; k++) begin
         u = $random(seed);
         wr(8'h04, {k[3:0], u[27:0]});
         wr(8'h00, {17'h0, 1'b1, 10'h0, k[7:4]});
         rd(8'h24);
         `chk("pass", cp(k[7:4], k[3:0]), v[0])
      end
      $display("conditions done");
      for (k = 0; k < 17; k++) begin
         b = $random(seed);
         im = $random(seed);
         wr(8'h04, b);
         wr(8'h14, im);
         wr(8'h00, {13'h0, k < 16 ? k[3:0] : 4'hf, 1'b1, 10'h1, k < 16 ? 4'he : 4'hf});
         for (op = 0; op < 4; op++)
            if (k < 16 && k[op]) b[31 - 8 * op -: 8] = im[31 - 8 * op -: 8];
         rd(8'h04);
         `chk("psr", b, v)
      end
      $display("status masks done");
      for (k = 0; k < 80; k++) begin
         u = $random(seed);
         b = $random(seed);
         o = $random(seed);
         im = $random(seed);
         op = k % 5;
         op = op + (op > 0);
         c = u[3:0];
         f = u[7:4];
         // register amounts stay below 32 so the reference shift stays simple
         wr(8'h04, {f, 28'h0});
         wr(8'h08, b);
         wr(8'h0c, o);
         wr(8'h10, {27'h0, u[27:23] | 5'h1});
         wr(8'h14, im);
         wr(8'h00, {6'h0, u[18:14] | 5'h1, u[22:21], 4'h0, u[19], u[20] && op == 0, 3'(u[13:11] % 5),
            2'(u[9:8] % 3), u[10], 3'(op), c});
         e = u[19] ? im : shf(o, u[13:11] % 5, (u[20] && op == 0) ? (u[27:23] | 1) : (u[18:14] | 1), f[1]);
         if (op == 2 && u[19]) e = im[11:0];
         if (op == 3) e = u[19] ? im[7:0] : o;
         if (op == 5) e = {im[7:0], 2'b0};
         nb = u[10] ? b + e : b - e;
         x = u[9:8] % 3 == 2 ? b : nb;
         if (op == 4) begin
            e = {im[4:0], 2'b0};
            nb = u[22] ? b - e : b + e;
            x = u[22] ? nb + (u[21] ? 0 : 4) : b + (u[21] ? 4 : 0);
         end
         if (u[9:8] % 3 == 0 || op == 0 || !cp(c, f)) nb = b;
         rd(8'h24);
         `chk("status", {cp(c, f), cp(c, f) && op > 0 && u[9:8] % 3 != 0, 1'b1}, {v[0], v[2], v[3]})
         rd(8'h08);
         `chk("base", nb, v)
         rd(8'h20);
         if (cp(c, f) && op > 0) `chk("xfer", x, v)
         rd(8'h1c);
         if (cp(c, f)) `chk("result", e, v)
      end
      $display("operands and addresses done");
      wr(8'h28, 32'h1);
      `chk("bresp", 2'h2, rs)
      rd(8'h28);
      `chk("rresp", 2'h2, rs)
      $display("unmapped done");
      final_report;
   end
endmodule
`default_nettype wire
